//--- lvdc_pkg.sv
// Package: register map, field layout and reset values of the voltage detector control
package lvdc_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_MASK = 4'h2;
   localparam logic [3:0] ADDR_FLAGS_IN = 4'h3;
   // Control register fields
   localparam int unsigned CTL_STABLE_BIT = 5;
   localparam int unsigned CTL_POWER_BIT = 4;
   localparam int unsigned CTL_TRIP_LSB = 0;
   localparam int unsigned CTL_TRIP_W = 4;
   localparam logic [3:0] TRIP_EXTERNAL = 4'hf;
   localparam logic [3:0] TRIP_RESERVED = 4'h0;
   localparam logic [3:0] TRIP_RESET = 4'h5;
   localparam logic POWER_RESET = 1'b0;
   // Status and mask register fields
   localparam int unsigned ST_LOW_VOLTAGE_BIT = 0;
   localparam int unsigned ST_STABLE_RISE_BIT = 1;
   localparam int unsigned ST_W = 2;
   localparam logic [1:0] ST_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;
   // Global interrupt enable register bit
   localparam int unsigned GIE_BIT = 0;
   typedef enum logic [1:0] {
      LVDC_OFF,
      LVDC_SETTLING,
      LVDC_ARMED
   } lvdc_state_t;
endpackage : lvdc_pkg

//--- lvdc_properties.sv
// Checker: port timing of the voltage detector control
module lvdc_properties
(
   // Clock, reset and register port
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   // Analog and core side
   input wire logic i_ref_ready,
   input wire logic i_sleeping,
   input wire logic o_detector_power_enable,
   input wire logic o_ref_power,
   input wire logic o_ext_input_select,
   input wire logic [3:0] o_tap_select,
   input wire logic o_wake,
   input wire logic o_vector_request,
   input wire logic o_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);
   a_reset_state: assert property (disable iff (1'b0)
      i_srst |=> o_tap_select == 4'h5 && !o_detector_power_enable && !o_irq)
      else $error("reset state wrong");
   a_ext_route: assert property (i_wr && i_addr == 4'h0 |=>
      o_ext_input_select == ($past(i_wdata[3:0]) == 4'hf)) else $error("external input select wrong");
   a_power_write: assert property (i_wr && i_addr == 4'h0 |=>
      o_detector_power_enable == $past(i_wdata[4])) else $error("power enable wrong");
   a_trip_write: assert property (i_wr && i_addr == 4'h0 |=>
      o_tap_select == $past(i_wdata[3:0])) else $error("trip select wrong");
   a_ref_shared: assert property ($past(o_detector_power_enable) &&
      o_detector_power_enable |-> o_ref_power) else $error("reference not powered");
   a_ctl_read: assert property (i_rd && i_addr == 4'h0 |=>
      o_rdata[7:6] == 2'b00 && (!o_rdata[5] || o_rdata[4])) else $error("control read wrong");
   a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00) else $error("read data not zero");
   a_wake_cause: assert property (o_wake |-> $past(i_sleeping) &&
      $past(i_ref_ready, 4)) else $error("wake without cause");
   a_vector_gate: assert property (o_vector_request |-> o_irq)
      else $error("vector without interrupt");
endmodule : lvdc_properties

bind lvdc_top lvdc_properties u_props (.*);

//--- lvdc_top.sv
// Control, status and interrupt logic of the supply voltage detector
//
// Decided for this implementation: the address-and-strobe port and the register offsets.

module lvdc_top
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Register port
   input wire logic [lvdc_pkg::ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Analog side
   input wire logic i_ref_ready,
   input wire logic i_cmp_below,
   input wire logic i_bor_enabled,
   output logic o_detector_power_enable,
   output logic o_ref_power,
   output logic o_ext_input_select,
   output logic [3:0] o_tap_select,
   // Core side
   input wire logic i_sleeping,
   output logic o_wake,
   output logic o_vector_request,
   output logic o_irq
);
   logic ref_meta_q, ref_meta_d, ref_sync_q, ref_sync_d;
   logic cmp_meta_q, cmp_meta_d, cmp_sync_q, cmp_sync_d;
   logic stable_prev_q, stable_prev_d;
   logic power_q, power_d;
   logic [3:0] trip_q, trip_d;
   logic [1:0] status_q, status_d;
   logic [1:0] mask_q, mask_d;
   logic gie_q, gie_d;
   logic [7:0] rdata_q, rdata_d;
   logic wake_q, wake_d, vec_q, vec_d, irq_q, irq_d;
   logic refpwr_q, refpwr_d, ext_q, ext_d;
   logic [3:0] tap_q, tap_d;
   lvdc_pkg::lvdc_state_t state_q, state_d;
   logic stable;
   logic [1:0] events;
   logic [1:0] clr;
   logic [1:0] pending;

   // Synchronisers for comparator and reference ready
   always_comb
   begin
      ref_meta_d = i_ref_ready;
      ref_sync_d = ref_meta_q;
      cmp_meta_d = i_cmp_below;
      cmp_sync_d = cmp_meta_q;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         ref_meta_q <= 1'b0;
         ref_sync_q <= 1'b0;
         cmp_meta_q <= 1'b0;
         cmp_sync_q <= 1'b0;
      end
      else
      begin
         ref_meta_q <= ref_meta_d;
         ref_sync_q <= ref_sync_d;
         cmp_meta_q <= cmp_meta_d;
         cmp_sync_q <= cmp_sync_d;
      end
   end

   // Stable comes only from the analog ready, gated by power
   assign stable = power_q && ref_sync_q;

   // Detector sequencing
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         lvdc_pkg::LVDC_OFF:
         begin
            if (power_q)
            begin
               state_d = lvdc_pkg::LVDC_SETTLING;
            end
         end
         lvdc_pkg::LVDC_SETTLING:
         begin
            if (!power_q)
            begin
               state_d = lvdc_pkg::LVDC_OFF;
            end
            else if (stable)
            begin
               state_d = lvdc_pkg::LVDC_ARMED;
            end
         end
         lvdc_pkg::LVDC_ARMED:
         begin
            if (!power_q)
            begin
               state_d = lvdc_pkg::LVDC_OFF;
            end
            else if (!stable)
            begin
               state_d = lvdc_pkg::LVDC_SETTLING;
            end
         end
         default:
         begin
            state_d = lvdc_pkg::LVDC_OFF;
         end
      endcase
   end

   // Events: trip only while armed, plus stable rising edge
   always_comb
   begin
      events = '0;
      // A trip seen while settling is dropped, never latched
      events[lvdc_pkg::ST_LOW_VOLTAGE_BIT] =
         (state_q == lvdc_pkg::LVDC_ARMED) && cmp_sync_q;
      events[lvdc_pkg::ST_STABLE_RISE_BIT] = stable && !stable_prev_q;
      stable_prev_d = stable;
   end

   // Register writes
   always_comb
   begin
      power_d = power_q;
      trip_d = trip_q;
      mask_d = mask_q;
      gie_d = gie_q;
      clr = '0;
      if (i_wr)
      begin
         case (i_addr)
            lvdc_pkg::ADDR_CONTROL:
            begin
               // Bits 7-5 are not writable
               power_d = i_wdata[lvdc_pkg::CTL_POWER_BIT];
               trip_d = i_wdata[lvdc_pkg::CTL_TRIP_LSB +: lvdc_pkg::CTL_TRIP_W];
            end
            lvdc_pkg::ADDR_STATUS:
            begin
               clr = i_wdata[lvdc_pkg::ST_W-1:0];
            end
            lvdc_pkg::ADDR_MASK:
            begin
               mask_d = i_wdata[lvdc_pkg::ST_W-1:0];
            end
            lvdc_pkg::ADDR_FLAGS_IN:
            begin
               gie_d = i_wdata[lvdc_pkg::GIE_BIT];
            end
            default:
            begin
               power_d = power_q;
            end
         endcase
      end
   end

   // Status flags, set beats clear so a trip is never lost to a clear
   always_comb
   begin
      status_d = (status_q & ~clr) | events;
   end

   // Interrupt and wake, from next values so they change with the status
   always_comb
   begin
      pending = status_d & mask_d;
      irq_d = |pending;
      // Low-voltage trip wakes the core from sleep regardless of the mask and global interrupt enables
      wake_d = i_sleeping && events[lvdc_pkg::ST_LOW_VOLTAGE_BIT];
      // Without the global enable the core resumes in line after waking
      vec_d = |pending && gie_d;
   end

   // Analog side controls
   always_comb
   begin
      refpwr_d = power_d || i_bor_enabled;
      ext_d = (trip_d == lvdc_pkg::TRIP_EXTERNAL);
      // Reserved code taps nothing; others select ascending divider nodes
      tap_d = (trip_d == lvdc_pkg::TRIP_RESERVED) ? lvdc_pkg::TRIP_RESERVED : trip_d;
   end

   // Read data, one cycle after the strobe
   always_comb
   begin
      rdata_d = '0;
      if (i_rd)
      begin
         case (i_addr)
            lvdc_pkg::ADDR_CONTROL:
            begin
               rdata_d[lvdc_pkg::CTL_STABLE_BIT] = stable;
               rdata_d[lvdc_pkg::CTL_POWER_BIT] = power_q;
               rdata_d[lvdc_pkg::CTL_TRIP_LSB +: lvdc_pkg::CTL_TRIP_W] = trip_q;
            end
            lvdc_pkg::ADDR_STATUS:
            begin
               rdata_d[lvdc_pkg::ST_W-1:0] = status_q;
            end
            lvdc_pkg::ADDR_MASK:
            begin
               rdata_d[lvdc_pkg::ST_W-1:0] = mask_q;
            end
            lvdc_pkg::ADDR_FLAGS_IN:
            begin
               rdata_d[lvdc_pkg::GIE_BIT] = gie_q;
            end
            default:
            begin
               rdata_d = '0;
            end
         endcase
      end
   end

   // Detector control registers
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         power_q <= lvdc_pkg::POWER_RESET;
         trip_q <= lvdc_pkg::TRIP_RESET;
         mask_q <= lvdc_pkg::MASK_RESET;
         gie_q <= 1'b0;
      end
      else
      begin
         power_q <= power_d;
         trip_q <= trip_d;
         mask_q <= mask_d;
         gie_q <= gie_d;
      end
   end

   // Sequencer state
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         state_q <= lvdc_pkg::LVDC_OFF;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // Status flags and stable edge history
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         status_q <= lvdc_pkg::ST_RESET;
         stable_prev_q <= 1'b0;
      end
      else
      begin
         status_q <= status_d;
         stable_prev_q <= stable_prev_d;
      end
   end

   // Read data register
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         rdata_q <= '0;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   // Interrupt and wake outputs
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         irq_q <= 1'b0;
         wake_q <= 1'b0;
         vec_q <= 1'b0;
      end
      else
      begin
         irq_q <= irq_d;
         wake_q <= wake_d;
         vec_q <= vec_d;
      end
   end

   // Analog side outputs
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         refpwr_q <= 1'b0;
         ext_q <= 1'b0;
         tap_q <= lvdc_pkg::TRIP_RESET;
      end
      else
      begin
         refpwr_q <= refpwr_d;
         ext_q <= ext_d;
         tap_q <= tap_d;
      end
   end

   assign o_rdata = rdata_q;
   assign o_detector_power_enable = power_q;
   assign o_ref_power = refpwr_q;
   assign o_ext_input_select = ext_q;
   assign o_tap_select = tap_q;
   assign o_wake = wake_q;
   assign o_vector_request = vec_q;
   assign o_irq = irq_q;
endmodule : lvdc_top

//--- lvdc_top_bench.sv
// Bench: drives the voltage detector control through its ports
module lvdc_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk, i_srst, i_wr, i_rd, i_ref_ready, i_cmp_below, i_bor_enabled, i_sleeping;
   logic [3:0] i_addr, o_tap_select;
   logic [7:0] i_wdata, o_rdata, v;
   logic o_detector_power_enable, o_ref_power, o_ext_input_select, o_wake;
   logic o_vector_request, o_irq;
   int fail_count, cmp_count, n;
   // Address, write value, expected read back with reference not ready
   logic [7:0] rows [9][3] = '{'{8'h02, 8'hff, 8'h03}, '{8'h02, 8'h00, 8'h00},
      '{8'h03, 8'hff, 8'h01}, '{8'h03, 8'h00, 8'h00}, '{8'h00, 8'hff, 8'h1f},
      '{8'h00, 8'hce, 8'h0e}, '{8'h00, 8'h31, 8'h11}, '{8'h00, 8'h20, 8'h00},
      '{8'h00, 8'h15, 8'h15}};
   lvdc_top dut (.*);
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         $display("BAD %s expected %h seen %h", s, e, g);
         fail_count++;
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(posedge i_clk);
      v = o_rdata;
   endtask : rd
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results
   initial
   begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   initial
   begin
      {i_wr, i_rd, i_ref_ready, i_cmp_below, i_bor_enabled, i_sleeping, i_addr, i_wdata} = '0;
      i_srst = 1'b1;
      repeat (12) @(posedge i_clk);
      i_srst <= 1'b0;
      rd(4'h0);
      chk("control reset", 8'h05, v);
      for (n = 0; n < 9; n++)
      begin
         wr(rows[n][0][3:0], rows[n][1]);
         rd(rows[n][0][3:0]);
         chk("register", rows[n][2], v);
         if (rows[n][0] == 8'h00)
         begin
            chk("power tap", {3'h0, rows[n][2][4:0]},
               {3'h0, o_detector_power_enable, o_tap_select});
            chk("ext", {7'h0, (rows[n][2][3:0] == 4'hf)}, {7'h0, o_ext_input_select});
         end
      end
      rd(4'h7);
      chk("unmapped", 8'h00, v);
      i_cmp_below <= 1'b1;
      repeat (10) @(posedge i_clk);
      rd(4'h1);
      chk("flag unstable", 8'h00, v);
      chk("ref power", 8'h01, {7'h0, o_ref_power});
      i_cmp_below <= 1'b0;
      i_ref_ready <= 1'b1;
      for (n = 0; n < 20 && v[5] !== 1'b1; n++)
         rd(4'h0);
      if (v[5] !== 1'b1)
      begin
         fail_count++;
         results();
      end
      chk("stable", 8'h35, v);
      rd(4'h1);
      chk("stable rise", 8'h02, v);
      wr(4'h1, 8'h03);
      rd(4'h1);
      chk("cleared", 8'h00, v);
      wr(4'h2, 8'h01);
      wr(4'h3, 8'h01);
      i_sleeping <= 1'b1;
      i_cmp_below <= 1'b1;
      for (n = 0; n < 20 && o_wake !== 1'b1; n++)
         @(posedge i_clk);
      if (o_wake !== 1'b1)
      begin
         fail_count++;
         results();
      end
      chk("wake irq vec", 8'h07, {5'h0, o_wake, o_irq, o_vector_request});
      i_sleeping <= 1'b0;
      wr(4'h3, 8'h00);
      repeat (4) @(posedge i_clk);
      chk("no vector", 8'h02, {5'h0, o_wake, o_irq, o_vector_request});
      i_cmp_below <= 1'b0;
      repeat (3) @(posedge i_clk);
      wr(4'h1, 8'h01);
      wr(4'h0, 8'h05);
      i_bor_enabled <= 1'b1;
      repeat (4) @(posedge i_clk);
      chk("bor ref", 8'h01, {6'h0, o_irq, o_ref_power});
      wr(4'h0, 8'h1e);
      i_srst <= 1'b1;
      @(posedge i_clk);
      i_srst <= 1'b0;
      rd(4'h0);
      chk("control rerun", 8'h05, v);
      results();
   end
endmodule : lvdc_top_bench
